// ===== rtl/smef_event_flags.sv
// mid slice of the read-to-clear event status word and its interrupt
// assumes event inputs come from logic on CLK_SYS; CS_B is a raw pin
//
// What this block does
// - wetting fault found by enabled diagnostic sets bit 11.
// - bit 11 stays zero without a new fault; cleared by status read.
// - active supply measurement changing state versus channel 1 sets bit 10.
// - finished checksum calculation sets bit 8.
// - finished checksum result becomes readable at offset 3h.
// - bit 8 zero while running, before start, and after status read.
// - under-voltage start and end each set bit 7.
// - over-voltage start and end each set bit 6.
// - status read returns contents, then clears all flags to default.
// - interrupt released at chip-select rise ending the status read.
`timescale 1ns/1ns
module smef_event_flags
  import smef_pkg::*;
(
  input wire logic CLK_SYS, // 20 MHz system clock
  input wire logic RST_B, // async reset, active low
  input wire logic CE, // clock enable, freezes state when low
  input wire logic CS_B, // serial chip select pin, active low
  input wire smef_pkg::smef_rd_req_t RD_REQ, // register read command
  input wire smef_pkg::smef_events_t EVT, // event sources
  input wire logic [smef_pkg::SMEF_CRC_W-1:0] CRC_VALUE, // checksum result
  output logic [smef_pkg::SMEF_DATA_W-1:0] RD_DATA, // read data
  output logic RD_VALID, // read data valid pulse
  output logic [5:0] FLAGS, // live flag slice
  output logic INT_B // interrupt, active low
);
  import smef_pkg::*;

  smef_state_t st_reg;
  smef_state_t st_next;
  logic [SMEF_CRC_W-1:0] crc_q;
  logic stat_rd;
  logic crc_rd;
  logic cs_rise;
  logic [5:0] set_v;
  logic [5:0] clr_v;

  function automatic logic changed2(input logic [1:0] a, input logic [1:0] b);
    changed2 = (a != b);
  endfunction

  smef_crc_hold #(
    .WIDTH(SMEF_CRC_W)
  ) u_crc_hold (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .ce(CE),
    .wr_en(EVT.crc_done),
    .wr_data(CRC_VALUE),
    .hold_q(crc_q)
  );

  always_comb begin
    st_next = st_reg;
    stat_rd = RD_REQ.strobe && (RD_REQ.addr == SMEF_STAT_OFFSET);
    crc_rd = RD_REQ.strobe && (RD_REQ.addr == SMEF_CRC_OFFSET);
    // second stage only sees the first stage
    st_next.cs_sync = {st_reg.cs_sync[0], CS_B};
    st_next.cs_prev = st_reg.cs_sync[1];
    cs_rise = st_reg.cs_sync[1] && !st_reg.cs_prev;

    set_v = '0;
    set_v[SMEF_F_WET] = EVT.wetting_fault_flag_en && EVT.wet_fault;
    set_v[SMEF_F_VS1] = EVT.vs_meas_en && st_reg.vs_base_ok
      && changed2(EVT.vs1_state, st_reg.vs1_prev);
    set_v[SMEF_F_VS0] = EVT.vs_meas_en && st_reg.vs_base_ok
      && changed2(EVT.vs0_state, st_reg.vs0_prev);
    set_v[SMEF_F_CRC] = EVT.crc_done;
    // both edges of the level count as an event
    set_v[SMEF_F_UV] = EVT.uv_level != st_reg.uv_prev;
    set_v[SMEF_F_OV] = EVT.ov_level != st_reg.ov_prev;

    clr_v = '0;
    if (stat_rd) begin
      clr_v = '1;
    end
    if (EVT.crc_start) begin
      clr_v[SMEF_F_CRC] = 1'b1;
    end
    // a set in the same cycle as the clear survives it
    st_next.flags = (st_reg.flags & ~clr_v) | set_v;

    st_next.uv_prev = EVT.uv_level;
    st_next.ov_prev = EVT.ov_level;
    st_next.vs1_prev = EVT.vs1_state;
    st_next.vs0_prev = EVT.vs0_state;
    // first active sample only takes a baseline, no event
    st_next.vs_base_ok = EVT.vs_meas_en;

    st_next.rvalid = stat_rd || crc_rd;
    if (stat_rd) begin
      st_next.rdata = SMEF_RDATA_RST;
      st_next.rdata[SMEF_BIT_WET:SMEF_SLICE_LO] = st_reg.flags;
    end else if (crc_rd) begin
      st_next.rdata = SMEF_RDATA_RST;
      st_next.rdata[SMEF_CRC_W-1:0] = crc_q;
    end

    if (stat_rd) begin
      st_next.rd_pend = 1'b1;
    end
    // pin held low until the frame of the read ends
    if (|set_v) begin
      st_next.int_act = 1'b1;
    end
    if (cs_rise && st_reg.rd_pend) begin
      st_next.rd_pend = 1'b0;
      st_next.int_act = |set_v || |st_reg.flags;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      st_reg.flags <= SMEF_FLAGS_RST;
      st_reg.cs_sync <= SMEF_SYNC_RST;
      st_reg.cs_prev <= 1'b1;
      st_reg.rd_pend <= 1'b0;
      st_reg.int_act <= 1'b0;
      st_reg.uv_prev <= 1'b0;
      st_reg.ov_prev <= 1'b0;
      st_reg.vs1_prev <= 2'h0;
      st_reg.vs0_prev <= 2'h0;
      st_reg.vs_base_ok <= 1'b0;
      st_reg.rdata <= SMEF_RDATA_RST;
      st_reg.rvalid <= 1'b0;
    end else if (CE) begin
      st_reg <= st_next;
    end
  end

  assign RD_DATA = st_reg.rdata;
  assign RD_VALID = st_reg.rvalid && CE;
  assign FLAGS = st_reg.flags;
  assign INT_B = !st_reg.int_act;
endmodule

// ===== rtl/smef_pkg.sv
// shared constants and types for the mid event-flag slice (bits 11..6)
// assumes the serial front end decodes commands into register reads
package smef_pkg;
  localparam int SMEF_DATA_W = 24;
  localparam int SMEF_ADDR_W = 6;
  localparam int SMEF_CRC_W = 16;
  localparam logic [5:0] SMEF_STAT_OFFSET = 6'h02;
  localparam logic [5:0] SMEF_CRC_OFFSET = 6'h03;
  // field positions inside the status word
  localparam int SMEF_BIT_WET = 11;
  localparam int SMEF_BIT_VS1 = 10;
  localparam int SMEF_BIT_VS0 = 9;
  localparam int SMEF_BIT_CRC = 8;
  localparam int SMEF_BIT_UV = 7;
  localparam int SMEF_BIT_OV = 6;
  localparam int SMEF_SLICE_LO = 6;
  // index of each flag inside the 6-bit slice
  localparam int SMEF_F_OV = 0;
  localparam int SMEF_F_UV = 1;
  localparam int SMEF_F_CRC = 2;
  localparam int SMEF_F_VS0 = 3;
  localparam int SMEF_F_VS1 = 4;
  localparam int SMEF_F_WET = 5;
  localparam logic [5:0] SMEF_FLAGS_RST = 6'h00;
  localparam logic [1:0] SMEF_SYNC_RST = 2'h3;
  localparam logic [SMEF_DATA_W-1:0] SMEF_RDATA_RST = 24'h000000;
  localparam logic [SMEF_CRC_W-1:0] SMEF_CRC_RST = 16'h0000;

  // register read request from the serial front end
  typedef struct packed {
    logic strobe;
    logic [SMEF_ADDR_W-1:0] addr;
  } smef_rd_req_t;

  // event sources from the diagnostic, measurement and supply logic
  typedef struct packed {
    logic wetting_fault_flag_en;
    logic wet_fault;
    logic vs_meas_en;
    logic [1:0] vs1_state;
    logic [1:0] vs0_state;
    logic crc_start;
    logic crc_done;
    logic uv_level;
    logic ov_level;
  } smef_events_t;

  typedef struct packed {
    logic [5:0] flags;
    logic [1:0] cs_sync;
    logic cs_prev;
    logic rd_pend;
    logic int_act;
    logic uv_prev;
    logic ov_prev;
    logic [1:0] vs1_prev;
    logic [1:0] vs0_prev;
    logic vs_base_ok;
    logic [SMEF_DATA_W-1:0] rdata;
    logic rvalid;
  } smef_state_t;
endpackage

// ===== rtl/smef_crc_hold.sv
// holding register for the checksum result, read data registered
// assumes write and capture strobes are on the system clock
`timescale 1ns/1ns
module smef_crc_hold #(
  parameter int WIDTH = 16
) (
  input wire logic clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic wr_en, // store new result
  input wire logic [WIDTH-1:0] wr_data, // result value
  output logic [WIDTH-1:0] hold_q // stored result
);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_q <= '0;
    end else if (ce && wr_en) begin
      hold_q <= wr_data;
    end
  end
endmodule

// ===== bench/smef_props.sv
// port assertions for the mid event-flag slice
// assumes it is bound onto smef_event_flags
`timescale 1ns/1ns
module smef_props
  import smef_pkg::*;
(
  input wire logic CLK_SYS, // clk
  input wire logic RST_B, // rst
  input wire logic CE, // run
  input wire logic CS_B, // sel
  input wire smef_pkg::smef_rd_req_t RD_REQ, // rd
  input wire smef_pkg::smef_events_t EVT, // evt
  input wire logic [15:0] CRC_VALUE, // sum
  input wire logic [23:0] RD_DATA, // data
  input wire logic RD_VALID, // vld
  input wire logic [5:0] FLAGS, // flags
  input wire logic INT_B // irq
);
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);
  a_wet_sets: assert property (CE && EVT.wetting_fault_flag_en && EVT.wet_fault
    |=> FLAGS[SMEF_F_WET]) else $error("wet flag missed");
  a_vs1_change: assert property (CE && $past(CE) && $past(RST_B)
    && EVT.vs_meas_en && $past(EVT.vs_meas_en) && $changed(EVT.vs1_state)
    |=> FLAGS[SMEF_F_VS1]) else $error("vs1 flag missed");
  a_crc_done: assert property (CE && EVT.crc_done
    |=> FLAGS[SMEF_F_CRC]) else $error("crc flag missed");
  a_crc_running: assert property (CE && EVT.crc_start && !EVT.crc_done
    |=> !FLAGS[SMEF_F_CRC]) else $error("crc flag while running");
  a_uv_edge: assert property (CE && $past(CE) && $past(RST_B)
    && $changed(EVT.uv_level) |=> FLAGS[SMEF_F_UV]) else $error("uv missed");
  a_ov_edge: assert property (CE && $past(CE) && $past(RST_B)
    && $changed(EVT.ov_level) |=> FLAGS[SMEF_F_OV]) else $error("ov missed");
  a_stat_read: assert property (CE && RD_REQ.strobe
    && RD_REQ.addr == SMEF_STAT_OFFSET |=> RD_VALID
    && RD_DATA == {12'h000, $past(FLAGS), 6'h00}) else $error("bad status");
  a_int_flags: assert property (|FLAGS |-> !INT_B)
    else $error("irq idle with flags");
endmodule
bind smef_event_flags smef_props chk_u (.*);

// ===== bench/smef_host.sv
// host model: one register read per select-low frame
// assumes go is a one-cycle pulse on the system clock
`timescale 1ns/1ns
module smef_host
  import smef_pkg::*;
(
  input wire logic clk, // clock
  input wire logic go, // start a read
  input wire logic [5:0] addr, // offset
  input wire logic [3:0] gap, // extra select-low cycles
  output logic cs_b, // select, idle high
  output smef_pkg::smef_rd_req_t req // read command
);
  logic [4:0] n = 5'h00;
  initial {cs_b, req} = 8'h80;
  always @(posedge clk) begin
    n <= cs_b ? 5'h00 : n + 5'h01;
    req <= '{!cs_b && n == 5'h01, addr};
    // the frame only ends after the command, so the release can follow
    if (go && cs_b) cs_b <= 1'b0;
    else if (!cs_b && n == {1'b0, gap} + 5'h02) cs_b <= 1'b1;
  end
endmodule

// ===== bench/smef_event_flags_test.sv
// bench for the mid event-flag slice; the host model does the reads
// CE held high except one frozen ev step; event word is {en,fault,meas,vs1,vs0,st,dn,uv,ov}
`timescale 1ns/1ns
`define CHK(a, b) begin \
  samples_checked++; \
  if ((a) !== (b)) begin \
    bad_count++; \
    $display("Error %0t: got %h want %h", $time, (a), (b)); \
  end \
end
module smef_event_flags_test;
  import smef_pkg::*;
  logic clk_sys, rst_b, ce, cs_b, go, rd_valid, int_b;
  logic [3:0] gap;
  logic [5:0] addr, flags;
  logic [23:0] rd_data;
  smef_rd_req_t rd_req;
  smef_events_t evt;
  int bad_count = 0;
  int samples_checked = 0;
  smef_event_flags dut_u (.CLK_SYS(clk_sys), .RST_B(rst_b), .CE(ce),
    .CS_B(cs_b), .RD_REQ(rd_req), .EVT(evt), .CRC_VALUE(16'hA5C3),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .FLAGS(flags), .INT_B(int_b));
  smef_host host_u (.clk(clk_sys), .go(go), .addr(addr), .gap(gap),
    .cs_b(cs_b), .req(rd_req));
  task automatic ev(input logic [10:0] v, input logic [6:0] x);
    evt <= v;
    repeat (2) @(posedge clk_sys);
    `CHK({flags, int_b}, x)
  endtask
  task automatic rd(input logic [5:0] a, input logic [3:0] g,
      input logic [23:0] x);
    {addr, gap, go} <= {a, g, 1'b1};
    @(posedge clk_sys);
    go <= 1'b0;
    for (int i = 0; i < 9 && rd_valid !== 1'b1; i++) @(posedge clk_sys);
    `CHK(rd_valid, 1'b1)
    `CHK(rd_data, x)
    while (cs_b !== 1'b1) @(posedge clk_sys);
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (2000) @(posedge clk_sys);
    bad_count++;
    test_done();
  end
  initial begin
    {rst_b, go, addr, gap, evt} = 23'h000000;
    ce = 1'b1;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    `CHK({flags, int_b}, 7'h01)
    ev(11'h003, 7'h06);
    rd(SMEF_STAT_OFFSET, 4'h3, 24'h0000C0);
    ev(11'h003, 7'h01);
    ev(11'h000, 7'h06);
    rd(SMEF_STAT_OFFSET, 4'h0, 24'h0000C0);
    ev(11'h000, 7'h01);
    ev(11'h200, 7'h01);
    ev(11'h600, 7'h40);
    ev(11'h400, 7'h40);
    ev(11'h408, 7'h40);
    ev(11'h404, 7'h48);
    rd(SMEF_CRC_OFFSET, 4'h1, 24'h00A5C3);
    ev(11'h408, 7'h40);
    ev(11'h500, 7'h40);
    ev(11'h540, 7'h60);
    ev(11'h560, 7'h70);
    rd(SMEF_STAT_OFFSET, 4'h5, 24'h000E00);
    ev(11'h560, 7'h01);
    // frozen state must not see the over-voltage edge until enabled
    ce <= 1'b0;
    ev(11'h561, 7'h01);
    ce <= 1'b1;
    ev(11'h561, 7'h02);
    test_done();
  end
endmodule
